// File: pmd_port.sv
// phy-side mii data, clock, carrier and collision port
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] mac changes the transmit nibble only with the phy transmit clock
// [RULE2] mac raises transmit enable exactly while the nibble is valid
// [RULE3] mac may raise transmit error, synchronous to the transmit clock
// [RULE4] phy sources transmit clock: 2.5 MHz at 10, 25 MHz at 100
// [RULE5] receive nibble changes with receive clock, bit 0 is least significant
// [RULE6] receive valid high exactly while a valid nibble is driven
// [RULE7] receive error raised, synchronous to receive clock, on error
// [RULE8] receive clock is 25 MHz at 100 and 2.5 MHz at 10
// [RULE9] collision output stays high for the whole collision
// [RULE10] collision output held low in full duplex
// [RULE11] half duplex: carrier sense while transmitting or receiving
// [RULE12] full duplex: carrier sense only while receiving
// [RULE13] carrier sense rises at once, falls on a receive clock edge
// [RULE14] management disable high makes all management accesses ignored
// [RULE15] management on: pins seed defaults in reset, writes own bits after
// [RULE16] pin reset or software reset, extended by 258 us after release
module pmd_port
	import pmd_pkg::*;
#(
	parameter int unsigned RESET_EXT = RESET_EXT_CYCLES
) (
	// clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// mii transmit side, from the mac
	input wire logic [3:0] mii_txd_i,
	input wire logic mii_tx_en_i,
	input wire logic mii_tx_er_i,
	output logic mii_tx_clk_o,
	// mii receive side, to the mac
	output logic [3:0] mii_rxd_o,
	output logic mii_rx_dv_o,
	output logic mii_rx_er_o,
	output logic mii_rx_clk_o,
	output logic mii_col_o,
	output logic mii_crs_o,
	// configuration pins
	input wire logic mgmt_port_disable_i,
	input wire logic cfg_duplex_i,
	input wire logic cfg_speed100_i,
	// management register requests
	input wire logic mgmt_wr_i,
	input wire logic mgmt_duplex_i,
	input wire logic mgmt_speed100_i,
	input wire logic mgmt_sw_reset_i,
	output logic mgmt_access_en_o,
	output logic duplex_o,
	output logic speed100_o,
	output logic reset_busy_o,
	// line side transmit
	output logic [3:0] line_tx_data_o,
	output logic line_tx_en_o,
	output logic line_tx_er_o,
	output logic line_tx_stb_o,
	// line side receive
	input wire logic line_rx_valid_i,
	input wire logic [3:0] line_rx_data_i,
	input wire logic line_rx_er_i,
	input wire logic line_rx_frame_i,
	output logic line_rx_ready_o,
	input wire logic line_carrier_i,
	input wire logic line_collision_i
);
	// three-stage pin synchroniser; a change is accepted once stages two
	// and three agree, so one metastable sample never reaches the logic
	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] sy1;
	logic [SYNC_W-1:0] sy2;
	logic [SYNC_W-1:0] sy3;
	logic [SYNC_W-1:0] pin_s;
	logic mdis_1;
	logic mdis_2;
	logic mdis_3;
	logic mdis_s;

	assign pin_raw = {cfg_speed100_i, cfg_duplex_i, mii_tx_er_i,
		mii_tx_en_i, mii_txd_i};

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			sy1 <= '0;
			sy2 <= '0;
			sy3 <= '0;
		end else if (ce_i) begin
			sy1 <= pin_raw;
			sy2 <= sy1;
			sy3 <= sy2;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			mdis_1 <= 1'b0;
			mdis_2 <= 1'b0;
			mdis_3 <= 1'b0;
		end else if (ce_i) begin
			mdis_1 <= mgmt_port_disable_i;
			mdis_2 <= mdis_1;
			mdis_3 <= mdis_2;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
			always_ff @(posedge sys_clk_i) begin
				if (!rstn_i) begin
					pin_s[gi] <= 1'b0;
				end else if (ce_i && (sy2[gi] == sy3[gi])) begin
					pin_s[gi] <= sy3[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			mdis_s <= 1'b0;
		end else if (ce_i && (mdis_2 == mdis_3)) begin
			mdis_s <= mdis_3;
		end
	end

	// reset combine and extension
	logic sw_reset;
	logic core_rst;
	logic [16:0] ext_cnt;

	assign sw_reset = ce_i && mgmt_wr_i && mgmt_sw_reset_i && !mdis_s;
	assign mgmt_access_en_o = !mdis_s && !reset_busy_o; // [RULE14]

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			ext_cnt <= 17'(RESET_EXT); // [RULE16]
		end else if (sw_reset) begin
			ext_cnt <= 17'(RESET_EXT); // [RULE16]
		end else if (ce_i && ext_cnt != '0) begin
			ext_cnt <= ext_cnt - 1'b1;
		end
	end

	assign reset_busy_o = (ext_cnt != '0);
	// a software reset clears the outputs on the same edge that reloads the
	// count, so nothing is still driven once reset_busy_o shows high
	assign core_rst = reset_busy_o || sw_reset; // [RULE16]

	// mode bits: pins seed during reset, then management or pins own them
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			duplex_o <= RST_DUPLEX;
			speed100_o <= RST_SPEED100;
		end else if (ce_i) begin
			if (core_rst || mdis_s) begin
				duplex_o <= pin_s[SY_DUP]; // [RULE15]
				speed100_o <= pin_s[SY_SPD]; // [RULE15]
			end else if (mgmt_wr_i) begin
				duplex_o <= mgmt_duplex_i; // [RULE15] [RULE14]
				speed100_o <= mgmt_speed100_i;
			end
		end
	end

	// mii clock divider; the same clock serves transmit and receive
	logic [5:0] div_cnt;
	logic [5:0] half_cnt;
	logic mii_clk;
	logic clk_rise;
	logic clk_fall;

	assign half_cnt = speed100_o ? HALF_100 : HALF_10; // [RULE4] [RULE8]
	// the toggle decode must match the divider's, or a speed change that
	// leaves the count past the new end would skip one sampling edge
	function automatic logic half_done(input logic [5:0] cnt,
		input logic [5:0] half);
		half_done = (cnt >= half - 6'h01);
	endfunction

	assign clk_rise = ce_i && half_done(div_cnt, half_cnt) && !mii_clk;
	assign clk_fall = ce_i && half_done(div_cnt, half_cnt) && mii_clk;

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			div_cnt <= '0;
			mii_clk <= 1'b0;
		end else if (ce_i) begin
			// a speed change that leaves the count past the new end restarts it at once
			if (half_done(div_cnt, half_cnt)) begin
				div_cnt <= '0;
				mii_clk <= !mii_clk; // [RULE4] [RULE8]
			end else begin
				div_cnt <= div_cnt + 1'b1;
			end
		end
	end

	assign mii_tx_clk_o = mii_clk;
	assign mii_rx_clk_o = mii_clk;

	// transmit sampling: mac moves on the rising edge, so sample at the fall;
	// at 100 Mbps the pin delay fills a half period, so each fall takes the
	// nibble launched one period earlier; order and count are kept
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i || core_rst) begin
			line_tx_stb_o <= 1'b0;
		end else if (ce_i) begin
			line_tx_stb_o <= clk_fall;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i || core_rst) begin
			line_tx_data_o <= '0;
			line_tx_en_o <= 1'b0;
			line_tx_er_o <= 1'b0;
		end else if (ce_i) begin
			if (clk_fall) begin
				line_tx_data_o <= pin_s[SY_TXD +: NIB_W]; // [RULE1]
				line_tx_en_o <= pin_s[SY_TXEN]; // [RULE2]
				line_tx_er_o <= pin_s[SY_TXER]; // [RULE3]
			end
		end
	end

	// receive buffer and nibble driver
	logic [RXW_W-1:0] rxf_data;
	logic rxf_valid;
	logic rxf_pop;
	logic fifo_rstn;
	logic fifo_ready;

	assign fifo_rstn = rstn_i && !core_rst;
	// the buffer reads empty in reset, so its ready must be masked there
	assign line_rx_ready_o = fifo_ready && !core_rst; // [RULE16]
	assign rxf_pop = clk_fall;

	pmd_fifo #(
		.WIDTH(RXW_W),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.sys_clk_i(sys_clk_i),
		.rstn_i(fifo_rstn),
		.ce_i(ce_i),
		.in_valid_i(line_rx_valid_i),
		.in_data_i({line_rx_er_i, line_rx_frame_i, line_rx_data_i}),
		.in_ready_o(fifo_ready),
		.out_valid_o(rxf_valid),
		.out_data_o(rxf_data),
		.out_ready_i(rxf_pop)
	);

	// the nibble changes on the clock's fall so the mac sees it stable at rise;
	// an empty buffer drops valid rather than repeat stale data
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i || core_rst) begin
			mii_rxd_o <= '0;
			mii_rx_dv_o <= 1'b0;
			mii_rx_er_o <= 1'b0;
		end else if (clk_fall) begin
			if (rxf_valid) begin
				mii_rxd_o <= rxf_data[NIB_W-1:0]; // [RULE5]
				mii_rx_dv_o <= rxf_data[RXW_DV]; // [RULE6]
				mii_rx_er_o <= rxf_data[RXW_ER]; // [RULE7]
			end else begin
				mii_rxd_o <= '0;
				mii_rx_dv_o <= 1'b0; // [RULE6]
				mii_rx_er_o <= 1'b0;
			end
		end
	end

	// carrier sense and collision
	logic tx_active;
	logic crs_cause;

	assign tx_active = pin_s[SY_TXEN];
	assign crs_cause = line_carrier_i ||
		(!duplex_o && tx_active); // [RULE11] [RULE12]

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i || core_rst) begin
			mii_crs_o <= 1'b0;
		end else if (ce_i) begin
			if (crs_cause) begin
				mii_crs_o <= 1'b1; // [RULE13]
			end else if (clk_rise) begin
				mii_crs_o <= 1'b0; // [RULE13]
			end
		end
	end

	// collision comes from the line's collision input, or from our own transmit against the line's carrier
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i || core_rst) begin
			mii_col_o <= 1'b0;
		end else if (ce_i) begin
			mii_col_o <= !duplex_o && (line_collision_i ||
				(tx_active && line_carrier_i)); // [RULE9] [RULE10]
		end
	end
endmodule

// File: pmd_pkg.sv
// constants shared by the mii data port and its buffer
package pmd_pkg;
	localparam int unsigned SYS_CLK_HZ = 200_000_000;
	localparam int unsigned MII_HZ_100 = 25_000_000;
	localparam int unsigned MII_HZ_10 = 2_500_000;
	localparam logic [5:0] HALF_100 = 6'(SYS_CLK_HZ / (2 * MII_HZ_100));
	localparam logic [5:0] HALF_10 = 6'(SYS_CLK_HZ / (2 * MII_HZ_10));
	localparam int unsigned RESET_EXT_US = 258;
	localparam int unsigned RESET_EXT_CYCLES =
		RESET_EXT_US * (SYS_CLK_HZ / 1_000_000);
	localparam int unsigned NIB_W = 4;
	localparam int unsigned RXW_W = 6;
	localparam int unsigned RXW_DV = 4;
	localparam int unsigned RXW_ER = 5;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned SYNC_W = 8;
	localparam int unsigned SY_TXD = 0;
	localparam int unsigned SY_TXEN = 4;
	localparam int unsigned SY_TXER = 5;
	localparam int unsigned SY_DUP = 6;
	localparam int unsigned SY_SPD = 7;
	localparam logic RST_DUPLEX = 1'b0;
	localparam logic RST_SPEED100 = 1'b1;
endpackage

// File: pmd_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module pmd_fifo #(
	parameter int unsigned WIDTH = 6,
	parameter int unsigned DEPTH = 8
) (
	// clock and control
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// fill side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// drain side
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready_o = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];
	assign push = ce_i && in_valid_i && in_ready_o;
	assign pop = ce_i && out_valid_o && out_ready_i;

	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

// File: pmd_port_assertions.sv
// concurrent checks on the mii data port outputs
`timescale 1ns/1ps
module pmd_port_assertions (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// watched ports
	input wire logic mii_tx_clk_o,
	input wire logic mii_rx_clk_o,
	input wire logic [3:0] mii_rxd_o,
	input wire logic mii_rx_dv_o,
	input wire logic mii_col_o,
	input wire logic mii_crs_o,
	input wire logic duplex_o,
	input wire logic speed100_o,
	input wire logic reset_busy_o,
	input wire logic line_rx_ready_o,
	input wire logic line_carrier_i,
	input wire logic line_collision_i,
	input wire logic mgmt_port_disable_i,
	input wire logic mgmt_access_en_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	a_clk_pair: assert property (mii_tx_clk_o == mii_rx_clk_o)
		else $error("clocks differ");
	a_col_full: assert property (duplex_o |=> !mii_col_o)
		else $error("collision in full duplex");
	a_col_set: assert property (ce_i && !reset_busy_o && !duplex_o &&
		line_collision_i |=> mii_col_o) else $error("collision missed");
	a_crs_set: assert property (ce_i && !reset_busy_o &&
		line_carrier_i |=> mii_crs_o) else $error("carrier missed");
	a_crs_fall: assert property ($fell(mii_crs_o) && !reset_busy_o
		|-> !$past(line_carrier_i)) else $error("carrier dropped early");
	// a stale nibble must not move while the mac may be sampling it
	a_rx_hold: assert property ($changed(mii_rxd_o) && !reset_busy_o
		|-> !mii_rx_clk_o) else $error("nibble moved off fall");
	a_dv_hold: assert property ($changed(mii_rx_dv_o) && !reset_busy_o
		|-> !mii_rx_clk_o) else $error("valid moved off fall");
	a_clk_fast: assert property (ce_i && speed100_o &&
		$changed(mii_rx_clk_o) |=> $stable(mii_rx_clk_o)[*3])
		else $error("fast clock half period too short");
	a_busy_quiet: assert property (reset_busy_o |-> !mii_rx_dv_o &&
		!mii_crs_o && !line_rx_ready_o) else $error("active in reset");
	a_mgmt_off: assert property ($rose(mgmt_port_disable_i)
		|-> ##[1:6] !mgmt_access_en_o) else $error("management not gated");
	a_busy_len: assert property ($rose(rstn_i) |->
		reset_busy_o[*8] ##[1:16] !reset_busy_o) else $error("bad extension");
endmodule
bind pmd_port pmd_port_assertions i_pmd_port_assertions (.*);

// File: pmd_mac_model.sv
// mac transmit side launching nibbles on the phy transmit clock
`timescale 1ns/1ps
module pmd_mac_model (
	// phy clock and bench requests
	input wire logic mii_tx_clk_i,
	input wire logic mac_send_i,
	input wire logic mac_err_i,
	input wire logic [3:0] mac_nib_i,
	// mii transmit pins
	output logic [3:0] mac_txd_o,
	output logic mac_tx_en_o,
	output logic mac_tx_er_o
);
	initial begin
		{mac_txd_o, mac_tx_en_o, mac_tx_er_o} = 6'h00;
	end
	// idle nibble inverts so a stale value never passes for data
	always @(posedge mii_tx_clk_i) begin
		mac_tx_en_o <= mac_send_i;
		mac_tx_er_o <= mac_send_i & mac_err_i;
		mac_txd_o <= mac_send_i ? mac_nib_i : ~mac_txd_o;
	end
endmodule

// File: pmd_port_test.sv
// self-checking bench for the mii data port
`timescale 1ns/1ps
module pmd_port_test;
	import pmd_pkg::*;
	logic sys_clk_i = 0, rstn_i = 0, ce_i = 1, mgmt_port_disable_i = 0;
	logic cfg_duplex_i = 0, cfg_speed100_i = 1, mgmt_wr_i = 0, full = 0;
	logic mgmt_duplex_i = 0, mgmt_speed100_i = 0, mgmt_sw_reset_i = 0;
	logic line_rx_valid_i = 0, line_rx_er_i = 0, line_rx_frame_i = 1;
	logic line_carrier_i = 0, line_collision_i = 0, send = 0, terr = 0;
	logic [3:0] line_rx_data_i = 0, tnib = 0, mii_txd_i, mii_rxd_o;
	logic [3:0] line_tx_data_o;
	logic mii_tx_en_i, mii_tx_er_i, mii_tx_clk_o, mii_rx_dv_o, mii_rx_er_o;
	logic mii_rx_clk_o, mii_col_o, mii_crs_o, mgmt_access_en_o, duplex_o;
	logic speed100_o, reset_busy_o, line_tx_en_o, line_tx_er_o;
	logic line_tx_stb_o, line_rx_ready_o;
	logic [31:0] seed = 32'h3e4d;
	logic [4:0] rq[$], tq[$];
	int num_errors = 0, checks = 0, n;
	pmd_port #(.RESET_EXT(20)) i_pmd_port (.*);
	pmd_mac_model i_pmd_mac_model (.mii_tx_clk_i(mii_tx_clk_o),
		.mac_send_i(send),
		.mac_err_i(terr), .mac_nib_i(tnib), .mac_txd_o(mii_txd_i),
		.mac_tx_en_o(mii_tx_en_i), .mac_tx_er_o(mii_tx_er_i));
	always #2.5 sys_clk_i = ~sys_clk_i;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [7:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic tick(input int c);
		repeat (c) @(negedge sys_clk_i);
	endtask
	task automatic gap(output int g);
		logic v;
		g = 0;
		v = mii_tx_clk_o;
		while (mii_tx_clk_o === v) begin
			tick(1);
			g++;
			if (g > 99) begin
				chk(0, 1);
				results();
			end
		end
	endtask
	task automatic idle();
		for (int k = 0; reset_busy_o !== 0; k++) begin
			tick(1);
			if (k > 60) begin
				chk(0, 1);
				results();
			end
		end
	endtask
	task automatic mw(input logic d, s, r);
		{mgmt_duplex_i, mgmt_speed100_i, mgmt_sw_reset_i} = {d, s, r};
		mgmt_wr_i = 1;
		tick(1);
		mgmt_wr_i = 0;
		tick(2);
	endtask
	always @(posedge sys_clk_i)
		if (rstn_i && line_rx_valid_i && line_rx_ready_o && line_rx_frame_i)
			rq.push_back({line_rx_er_i, line_rx_data_i});
	always @(posedge mii_rx_clk_o)
		if (mii_rx_dv_o)
			chk({mii_rx_er_o, mii_rxd_o}, rq.pop_front());
	always @(posedge mii_tx_clk_o)
		if (send)
			tq.push_back({terr, tnib});
	always @(negedge sys_clk_i)
		if (line_tx_stb_o && line_tx_en_o)
			chk({line_tx_er_o, line_tx_data_o}, tq.pop_front());
	initial begin
		tick(8);
		rstn_i = 1;
		idle();
		chk(duplex_o, RST_DUPLEX);
		chk(speed100_o, RST_SPEED100);
		gap(n);
		gap(n);
		chk(8'(n), HALF_100);
		// back to back pushes outrun the drain, so the buffer must refuse
		for (int i = 0; i < 14; i++) begin
			{line_rx_frame_i, line_rx_er_i, line_rx_data_i} = 6'(rnd());
			line_rx_valid_i = 1;
			tick(1);
			full |= !line_rx_ready_o;
		end
		line_rx_valid_i = 0;
		tick(120);
		chk(full, 1);
		chk(8'(rq.size()), 0);
		chk(mii_rx_dv_o, 0);
		line_collision_i = 1;
		tick(2);
		chk(mii_col_o, 1);
		mw(1, 1, 0);
		chk(mii_col_o, 0);
		line_collision_i = 0;
		send = 1;
		tick(30);
		chk(mii_crs_o, 0);
		line_carrier_i = 1;
		tick(2);
		chk(mii_crs_o, 1);
		line_carrier_i = 0;
		mw(0, 1, 0);
		tick(30);
		chk(mii_crs_o, 1);
		send = 0;
		tick(30);
		chk(mii_crs_o, 0);
		mw(0, 0, 0);
		gap(n);
		gap(n);
		chk(8'(n), HALF_10);
		tq.delete();
		send = 1;
		repeat (6) begin
			{terr, tnib} = 5'(rnd());
			tick(2 * HALF_10);
		end
		send = 0;
		tick(200);
		chk(8'(tq.size()), 0);
		mgmt_port_disable_i = 1;
		tick(8);
		chk(mgmt_access_en_o, 0);
		mw(1, 0, 1);
		chk(duplex_o, 0);
		chk(reset_busy_o, 0);
		chk(speed100_o, cfg_speed100_i);
		mgmt_port_disable_i = 0;
		cfg_duplex_i = 1;
		tick(8);
		mw(1, 1, 1);
		chk(reset_busy_o, 1);
		idle();
		chk(duplex_o, cfg_duplex_i);
		mw(0, 1, 0);
		chk(duplex_o, 0);
		results();
	end
endmodule
